/* core/psbsp_pkg.sv */
// package: widths, organisation and operation codes of the burst sram port
// assumes: one 200 mhz clock, x36 organisation built in
package psbsp_pkg;
	// ---------------------------------------------------------------
	// organisation
	// ---------------------------------------------------------------
	localparam int PSBSP_ADDR_W = 20;
	localparam int PSBSP_WORDS = 1 << PSBSP_ADDR_W;
	localparam int PSBSP_LANES = 4;
	localparam int PSBSP_LANE_W = 9;
	localparam int PSBSP_DATA_W = PSBSP_LANES * PSBSP_LANE_W;
	localparam int PSBSP_BURST_W = 2;
	// x18 organisation figures, kept for reference of the narrow build
	localparam int PSBSP_X18_ADDR_W = 21;
	localparam int PSBSP_X18_LANES = 2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam real PSBSP_CLOCK_NS = 5.0;
	localparam int PSBSP_READ_LATENCY = 2;
	localparam int PSBSP_WRITE_LATENCY = 2;

	// ---------------------------------------------------------------
	// pipeline operation codes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PSBSP_OP_IDLE = 3'h1,
		PSBSP_OP_READ = 3'h2,
		PSBSP_OP_WRITE = 3'h4
	} psbsp_op_e;

	localparam logic [PSBSP_BURST_W-1:0] PSBSP_BURST_ONE = 2'h1;
	localparam logic [PSBSP_BURST_W-1:0] PSBSP_BURST_ZERO = 2'h0;
	localparam logic [PSBSP_ADDR_W-1:0] PSBSP_ADDR_RESET = 20'h0_0000;
	localparam logic [PSBSP_DATA_W-1:0] PSBSP_DATA_RESET = 36'h0_0000_0000;
	localparam logic [PSBSP_LANES-1:0] PSBSP_LANES_OFF = 4'hF;
endpackage

/* core/psbsp_burst_if.sv */
// interface: burst low-address request and result between port and sequencer
// assumes: purely combinational exchange inside one clock domain
interface psbsp_burst_if;
	import psbsp_pkg::*;
	logic [PSBSP_BURST_W-1:0] base;
	logic [PSBSP_BURST_W-1:0] count;
	logic linear;
	logic [PSBSP_BURST_W-1:0] low;
	modport gen(input base, input count, input linear, output low);
	modport user(output base, output count, output linear, input low);
endinterface

/* core/psbsp_burst_seq.sv */
// burst sequencer: low address bits for linear or interleaved order
// assumes: count is the beat index already advanced by the caller
module psbsp_burst_seq
	import psbsp_pkg::*;
(
	// burst exchange
	psbsp_burst_if.gen bus
);
	// ---------------------------------------------------------------
	// order select
	// ---------------------------------------------------------------
	assign bus.low = bus.linear ? PSBSP_BURST_W'(bus.base + bus.count) : (bus.base ^ bus.count);
endmodule

/* core/psbsp_port.sv */
// pipelined synchronous burst sram port, 1m x 36, zero turnaround
// assumes: all inputs synchronous to clock; dq wire resolved outside from dq_oe
module psbsp_port
	import psbsp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// command
	input wire logic cycle_hold_n,
	input wire logic [PSBSP_ADDR_W-1:0] addr,
	input wire logic advance_load,
	input wire logic write_n,
	input wire logic [PSBSP_LANES-1:0] byte_lane_write_n,
	input wire logic burst_linear,
	// selection
	input wire logic select_low_first_n,
	input wire logic select_high_second,
	input wire logic select_low_third_n,
	input wire logic output_gate_n,
	input wire logic sleep_request,
	// data
	input wire logic [PSBSP_DATA_W-1:0] dq_in,
	output logic [PSBSP_DATA_W-1:0] dq_out,
	output logic dq_oe
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic en;
	logic selected;
	psbsp_op_e s1_op, s2_op, last_op;
	logic [PSBSP_ADDR_W-1:0] s1_addr, s2_addr;
	logic [PSBSP_LANES-1:0] s1_lanes_n, s2_lanes_n;
	logic [PSBSP_ADDR_W-PSBSP_BURST_W-1:0] burst_hi;
	logic [PSBSP_BURST_W-1:0] burst_base, burst_count;
	logic [PSBSP_BURST_W-1:0] next_count;
	logic drive;
	logic [PSBSP_DATA_W-1:0] mem [PSBSP_WORDS];
	logic [PSBSP_DATA_W-1:0] mem_rd;
	logic [PSBSP_DATA_W-1:0] wr_word;
	psbsp_burst_if burst ();

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	function automatic psbsp_op_e cmd_op(input logic wn);
		return wn ? PSBSP_OP_READ : PSBSP_OP_WRITE;
	endfunction

	assign en = ~cycle_hold_n;
	assign selected = ~select_low_first_n & select_high_second & ~select_low_third_n;
	assign next_count = PSBSP_BURST_W'(burst_count + PSBSP_BURST_ONE);
	assign burst.base = burst_base;
	assign burst.count = next_count;
	assign burst.linear = burst_linear;

	psbsp_burst_seq u_seq (
		.bus(burst.gen)
	);

	// ---------------------------------------------------------------
	// stage 1: input register and burst tracking
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s1_op <= PSBSP_OP_IDLE;
			s1_addr <= PSBSP_ADDR_RESET;
			s1_lanes_n <= PSBSP_LANES_OFF;
			last_op <= PSBSP_OP_IDLE;
			burst_hi <= '0;
			burst_base <= PSBSP_BURST_ZERO;
			burst_count <= PSBSP_BURST_ZERO;
		end else if (en) begin
			s1_lanes_n <= byte_lane_write_n;
			if (sleep_request) begin
				s1_op <= PSBSP_OP_IDLE;
				last_op <= PSBSP_OP_IDLE;
			end else if (advance_load) begin
				s1_op <= last_op;
				s1_addr <= {burst_hi, burst.low};
				burst_count <= next_count;
			end else if (selected) begin
				s1_op <= cmd_op(write_n);
				last_op <= cmd_op(write_n);
				s1_addr <= addr;
				burst_hi <= addr[PSBSP_ADDR_W-1:PSBSP_BURST_W];
				burst_base <= addr[PSBSP_BURST_W-1:0];
				burst_count <= PSBSP_BURST_ZERO;
			end else begin
				s1_op <= PSBSP_OP_IDLE;
				last_op <= PSBSP_OP_IDLE;
			end
		end
	end

	// ---------------------------------------------------------------
	// stage 2: data phase command
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s2_op <= PSBSP_OP_IDLE;
			s2_addr <= PSBSP_ADDR_RESET;
			s2_lanes_n <= PSBSP_LANES_OFF;
		end else if (en) begin
			s2_op <= s1_op;
			s2_addr <= s1_addr;
			s2_lanes_n <= s1_lanes_n;
		end
	end

	// ---------------------------------------------------------------
	// array and byte merge
	// ---------------------------------------------------------------
	assign mem_rd = mem[s2_addr];

	for (genvar l = 0; l < PSBSP_LANES; l++) begin : g_lane
		assign wr_word[l*PSBSP_LANE_W +: PSBSP_LANE_W] = s2_lanes_n[l] ?
			mem_rd[l*PSBSP_LANE_W +: PSBSP_LANE_W] : dq_in[l*PSBSP_LANE_W +: PSBSP_LANE_W];
	end

	// one enabled edge commits the word, no external pulse needed
	always_ff @(posedge clock) begin
		if (en && s2_op == PSBSP_OP_WRITE) begin
			mem[s2_addr] <= wr_word;
		end
	end

	// ---------------------------------------------------------------
	// output register and driver control
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dq_out <= PSBSP_DATA_RESET;
			drive <= 1'b0;
		end else if (en) begin
			case (s2_op)
				PSBSP_OP_READ: begin
					dq_out <= mem_rd;
					drive <= 1'b1;
				end
				PSBSP_OP_WRITE: begin
					drive <= 1'b0;
				end
				PSBSP_OP_IDLE: begin
					drive <= 1'b0;
				end
				default: begin
					drive <= 1'b0;
				end
			endcase
		end
	end

	// output gate acts without the clock
	assign dq_oe = drive & ~output_gate_n;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	a_capture_select: assert property (en && selected && !sleep_request && !advance_load
		|=> s1_op == cmd_op($past(write_n)) && s1_addr == $past(addr))
		else $error("selected command not captured");
	a_read_two_edges: assert property (en && s1_op == PSBSP_OP_READ ##1 en
		|=> drive && dq_out == $past(mem_rd))
		else $error("read data not out two edges after address");
	a_hold_freeze: assert property (!en |=> $stable(s1_op) && $stable(s2_op) && $stable(dq_out)
		&& $stable(drive))
		else $error("pipeline moved while held");
	for (genvar l = 0; l < PSBSP_LANES; l++) begin : g_lane_chk
		a_lane_keep: assert property (en && s2_op == PSBSP_OP_WRITE && s2_lanes_n[l]
			|=> mem[$past(s2_addr)][l*PSBSP_LANE_W +: PSBSP_LANE_W] == $past(mem_rd[l*PSBSP_LANE_W +: PSBSP_LANE_W]))
			else $error("unselected lane altered");
		a_lane_write: assert property (en && s2_op == PSBSP_OP_WRITE && !s2_lanes_n[l]
			|=> mem[$past(s2_addr)][l*PSBSP_LANE_W +: PSBSP_LANE_W] == $past(dq_in[l*PSBSP_LANE_W +: PSBSP_LANE_W]))
			else $error("selected lane not written");
	end
	a_deselect_idle: assert property (en && !selected && !advance_load |=> s1_op == PSBSP_OP_IDLE)
		else $error("deselected cycle started an access");
	a_write_hiz: assert property (en && s2_op == PSBSP_OP_WRITE |=> !dq_oe)
		else $error("drivers on during write data");
	a_idle_quiet: assert property (en && s2_op == PSBSP_OP_IDLE |=> !dq_oe)
		else $error("drivers on for an idle slot");
	a_no_bubble: assert property (en && s1_op != PSBSP_OP_IDLE |=> s2_op == $past(s1_op))
		else $error("pipeline inserted a gap");
	a_burst_page: assert property (en && advance_load && !sleep_request
		|=> s1_addr[PSBSP_ADDR_W-1:PSBSP_BURST_W] == $past(burst_hi))
		else $error("burst left its block");
	a_burst_op: assert property (en && advance_load && !sleep_request
		|=> s1_op == $past(last_op))
		else $error("burst beat lost its operation");
	a_sleep_idle: assert property (en && sleep_request |=> s1_op == PSBSP_OP_IDLE ##1 1)
		else $error("access started in sleep");
	a_write_commit: assert property (en && s2_op == PSBSP_OP_WRITE && s2_lanes_n == '0
		|=> mem[$past(s2_addr)] == $past(dq_in))
		else $error("full write not committed");

	c_read: cover property (en && s2_op == PSBSP_OP_READ ##1 dq_oe);
	c_write_read: cover property (en && s2_op == PSBSP_OP_WRITE ##1 en && s2_op == PSBSP_OP_READ);
	c_burst: cover property (en && advance_load && last_op != PSBSP_OP_IDLE);
	c_hold: cover property (en && s1_op != PSBSP_OP_IDLE ##1 !en ##1 en);
	c_sleep: cover property (en && sleep_request && selected && !advance_load);
endmodule

/* verif/psbsp_ctrl_model.sv */
// controller data side: drives write data two enabled edges after the command
// assumes: bench flags each taken write beat at its command edge
module psbsp_ctrl_model
	import psbsp_pkg::*;
(
	// clock
	input wire logic clock,
	input wire logic cycle_hold_n,
	// command side
	input wire logic wr_now,
	input wire logic [PSBSP_DATA_W-1:0] wd_now,
	// data bus
	output logic [PSBSP_DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] v = 2'h0;
	logic [PSBSP_DATA_W-1:0] d0, d1;
	logic [PSBSP_DATA_W-1:0] junk = '0;
	always @(posedge clock) begin
		junk <= ~junk;
		if (!cycle_hold_n) begin
			v <= {v[0], wr_now};
			d0 <= wd_now;
			d1 <= d0;
		end
	end
	// released bus toggles every cycle
	assign dq_in = v[1] ? d1 : junk;
endmodule

/* verif/psbsp_port_test.sv */
// bench for the burst sram port: reference memory and pipeline, scenario tasks
// assumes: controller model supplies write data on dq_in
module psbsp_port_test
	import psbsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0;
	logic resetn, cycle_hold_n, advance_load, write_n, burst_linear, output_gate_n, sleep_request, wr_now;
	logic select_low_first_n, select_high_second, select_low_third_n, dq_oe, bv, bw, nv, exp_oe;
	logic [PSBSP_ADDR_W-1:0] addr, ba, na;
	logic [PSBSP_LANES-1:0] byte_lane_write_n;
	logic [PSBSP_DATA_W-1:0] dq_in, dq_out, wd_now, exp_d, tmp;
	logic [1:0] pv, pw, bk;
	logic [PSBSP_ADDR_W-1:0] pa [2];
	logic [PSBSP_LANES-1:0] pl [2];
	logic [PSBSP_DATA_W-1:0] mem_ref [int];
	int err_count, total_checks;

	psbsp_port u_psbsp_port (.clock, .resetn, .cycle_hold_n, .addr, .advance_load, .write_n, .byte_lane_write_n,
		.burst_linear, .select_low_first_n, .select_high_second, .select_low_third_n, .output_gate_n,
		.sleep_request, .dq_in, .dq_out, .dq_oe);
	psbsp_ctrl_model u_psbsp_ctrl_model (.clock, .cycle_hold_n, .wr_now, .wd_now, .dq_in);

	always #2.5 clock = ~clock;

	// ---------------------------------------------------------------
	// reference pipeline
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (!resetn) begin
			pv = 2'h0;
			bv = 1'h0;
			exp_oe = 1'h0;
		end else if (!cycle_hold_n) begin
			if (pv[1] && pw[1]) begin
				tmp = mem_ref.exists(pa[1]) ? mem_ref[pa[1]] : dq_in;
				for (int l = 0; l < PSBSP_LANES; l++)
					if (!pl[1][l]) tmp[l*PSBSP_LANE_W+:PSBSP_LANE_W] = dq_in[l*PSBSP_LANE_W+:PSBSP_LANE_W];
				mem_ref[pa[1]] = tmp;
			end
			exp_oe = pv[1] && !pw[1];
			if (exp_oe) exp_d = mem_ref[pa[1]];
			nv = !sleep_request && (advance_load ? bv : !select_low_first_n && select_high_second && !select_low_third_n);
			bk = advance_load ? bk + 2'h1 : 2'h0;
			if (!advance_load) begin
				ba = addr;
				bw = !write_n;
			end
			na = {ba[PSBSP_ADDR_W-1:2], burst_linear ? ba[1:0] + bk : ba[1:0] ^ bk};
			bv = nv;
			pv = {pv[0], nv};
			pw = {pw[0], bw};
			pa[1] = pa[0];
			pa[0] = na;
			pl[1] = pl[0];
			pl[0] = byte_lane_write_n;
		end
	end

	always @(negedge clock) begin
		#1;
		if (resetn) begin
			chk(dq_oe, exp_oe && !output_gate_n, "drive");
			if (exp_oe && !output_gate_n) chk(dq_out, exp_d, "data");
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task chk(input logic [PSBSP_DATA_W-1:0] got, input logic [PSBSP_DATA_W-1:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task go(input logic adv, wn, input logic [PSBSP_ADDR_W-1:0] a, input logic [PSBSP_LANES-1:0] ln,
		input logic wf, input logic sel = 1'h1, input logic hn = 1'h0);
		@(negedge clock);
		advance_load = adv;
		write_n = wn;
		addr = a;
		byte_lane_write_n = ln;
		wr_now = wf;
		wd_now = {a[15:0], ~a} ^ {9{ln}};
		select_low_first_n = !sel;
		cycle_hold_n = hn;
	endtask

	task idle(input int n);
		repeat (n) go(1'h0, 1'h1, '0, 4'hF, 1'h0, 1'h0);
	endtask

	task t_rw;
		for (int i = 0; i < 4; i++) begin
			go(1'h0, 1'h0, 20'hF_FFFC + i, 4'h0, 1'h1);
			go(1'h0, 1'h1, 20'hF_FFFC + i, 4'h0, 1'h0);
		end
		idle(3);
	endtask

	task t_lanes;
		go(1'h0, 1'h0, 20'h0_0040, 4'h0, 1'h1);
		for (int l = 0; l < PSBSP_LANES; l++) begin
			go(1'h0, 1'h0, 20'h0_0040, ~(4'h1 << l), 1'h1);
			go(1'h0, 1'h1, 20'h0_0040, 4'hF, 1'h0);
		end
		idle(3);
	endtask

	task t_hold;
		go(1'h0, 1'h0, 20'h0_0050, 4'h0, 1'h1);
		go(1'h0, 1'h1, 20'h0_0050, 4'h0, 1'h0);
		repeat (3) go(1'h0, 1'h0, 20'h0_0040, 4'h0, 1'h0, 1'h1, 1'h1);
		go(1'h0, 1'h1, 20'h0_0040, 4'hF, 1'h0);
		idle(3);
	endtask

	task t_sel;
		for (int k = 0; k < 3; k++) begin
			go(1'h0, 1'h0, 20'h0_0050, 4'h0, 1'h0, k != 0);
			select_high_second = k != 1;
			select_low_third_n = k == 2;
		end
		go(1'h0, 1'h1, 20'h0_0050, 4'hF, 1'h0);
		select_low_third_n = 1'h0;
		go(1'h0, 1'h1, 20'h0_0040, 4'hF, 1'h0);
		output_gate_n = 1'h1;
		idle(3);
		output_gate_n = 1'h0;
		idle(2);
	endtask

	task t_burst;
		for (int m = 0; m < 2; m++) begin
			burst_linear = m[0];
			for (int b = 0; b < 4; b++) go(b != 0, 1'h0, 20'h0_0101 + b, 4'h0, 1'h1);
			for (int b = 0; b < 4; b++) go(b != 0, 1'h1, 20'h0_0101, 4'hF, 1'h0);
			for (int b = 0; b < 4; b++) begin
				go(b != 0, 1'h1, 20'h0_0101, 4'hF, 1'h0);
				if (b == 0) burst_linear = !m[0];
			end
			idle(3);
		end
	endtask

	task t_sleep;
		go(1'h0, 1'h0, 20'h0_0060, 4'h0, 1'h1);
		go(1'h0, 1'h1, 20'h0_0060, 4'hF, 1'h0);
		sleep_request = 1'h1;
		go(1'h1, 1'h1, 20'h0_0060, 4'hF, 1'h0);
		sleep_request = 1'h0;
		go(1'h0, 1'h1, 20'h0_0060, 4'hF, 1'h0);
		idle(3);
	endtask

	task summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		resetn = 1'h0;
		cycle_hold_n = 1'h0;
		{advance_load, wr_now, output_gate_n, sleep_request, select_low_third_n} = '0;
		{write_n, burst_linear, select_low_first_n, select_high_second} = '1;
		addr = '0;
		byte_lane_write_n = 4'hF;
		wd_now = '0;
		repeat (10) @(negedge clock);
		resetn = 1'h1;
		t_rw;
		t_lanes;
		t_hold;
		t_sel;
		t_burst;
		t_sleep;
		summarize;
	end

	initial begin
		#3000;
		err_count++;
		$display("BAD t=%0t timeout", $time);
		summarize;
	end
endmodule
